// [common/ccr_pkg.sv]
// Package of offsets, field positions and codes for clock config register one
package ccr_pkg;

    // Register offset and reset value
    localparam logic [7:0]  CCR_CFG1_OFFSET   = 8'h2C;
    localparam logic [31:0] CCR_CFG1_RESET    = 32'h0000_0000;
    // Write mask: implemented bits 30:29 and 18:0
    localparam logic [31:0] CCR_CFG1_MASK     = 32'h6007_FFFF;

    // Field positions
    localparam int CCR_MAIN_PLL_REF_BIT       = 30;
    localparam int CCR_ADC_PSC_MSB_BIT        = 29;
    localparam int CCR_AUDIO2_SEL_BIT         = 18;
    localparam int CCR_AUDIO1_SEL_BIT         = 17;
    localparam int CCR_PREDIV0_SEL_BIT        = 16;
    localparam int CCR_PLLB_MUL_LSB           = 12;
    localparam int CCR_PLLA_MUL_LSB           = 8;
    localparam int CCR_PREDIV1_LSB            = 4;
    localparam int CCR_PREDIV0_LSB            = 0;

    // Multiplier code range limits
    localparam logic [3:0] CCR_MUL_CODE_X8    = 4'h6;
    localparam logic [3:0] CCR_MUL_CODE_X14   = 4'hC;
    localparam logic [3:0] CCR_MUL_CODE_X16   = 4'hE;
    localparam logic [3:0] CCR_MUL_CODE_X20   = 4'hF;
    localparam logic [4:0] CCR_MUL_BASE       = 5'h02;
    localparam logic [4:0] CCR_MUL_16         = 5'h10;
    localparam logic [4:0] CCR_MUL_20         = 5'h14;
    localparam logic [4:0] CCR_MUL_RESERVED   = 5'h00;

    // AXI response codes
    localparam logic [1:0] CCR_RESP_OKAY      = 2'h0;
    localparam logic [1:0] CCR_RESP_SLVERR    = 2'h2;

    // Decode a 4-bit multiplier code; zero marks a reserved code
    function automatic logic [4:0] ccr_mul_decode(input logic [3:0] code);
        logic [4:0] f;
        f = CCR_MUL_RESERVED;
        if (code >= CCR_MUL_CODE_X8 && code <= CCR_MUL_CODE_X14) begin
            f = {1'b0, code} + CCR_MUL_BASE;
        end else if (code == CCR_MUL_CODE_X16) begin
            f = CCR_MUL_16;
        end else if (code == CCR_MUL_CODE_X20) begin
            f = CCR_MUL_20;
        end
        return f;
    endfunction : ccr_mul_decode

endpackage : ccr_pkg

// [hdl/ccr_prediv.sv]
// Clock-enable style pre-divider dividing by code plus one
`timescale 1ns/1ps
`default_nettype none
module ccr_prediv
    import ccr_pkg::*;
#(
    parameter int W = 4
) (
    // Clock and reset
    input  wire logic         aclk,
    input  wire logic         aresetn,
    // Source tick and division code
    input  wire logic         src_tick,
    input  wire logic [W-1:0] div_code,
    // Divided tick
    output logic              div_tick
);

    logic [W-1:0] count;       // Source ticks seen in this period
    logic [W-1:0] next_count;
    logic         next_tick;

    // Count source ticks, emit one tick every code plus one
    always_comb begin
        next_count = count;
        next_tick  = 1'b0;
        if (src_tick) begin
            if (count >= div_code) begin
                next_count = '0;
                next_tick  = 1'b1;
            end else begin
                next_count = count + 1'b1;
            end
        end
    end

    // Register counter and tick
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count    <= '0;
            div_tick <= 1'b0;
        end else begin
            count    <= next_count;
            div_tick <= next_tick;
        end
    end

endmodule : ccr_prediv
`default_nettype wire

// [hdl/ccr_src_mux.sv]
// Registered two-way source tick selector
`timescale 1ns/1ps
`default_nettype none
module ccr_src_mux (
    // Clock and reset
    input  wire logic aclk,
    input  wire logic aresetn,
    // Sources and select
    input  wire logic src0,
    input  wire logic src1,
    input  wire logic sel,
    // Selected tick
    output logic      out
);

    logic next_out;            // Selected source

    // Pick a source
    always_comb begin
        next_out = sel ? src1 : src0;
    end

    // Register the choice
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            out <= 1'b0;
        end else begin
            out <= next_out;
        end
    end

endmodule : ccr_src_mux
`default_nettype wire

// [hdl/ccr_cfg1.sv]
// Clock configuration register one with AXI4-Lite slave and selection logic
//
// Added by the designer: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module ccr_cfg1
    import ccr_pkg::*;
(
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // AXI4-Lite write address
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [7:0]  s_axi_awaddr,
    // AXI4-Lite write data
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    // AXI4-Lite write response
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    output logic [1:0]       s_axi_bresp,
    // AXI4-Lite read address
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    input  wire logic [7:0]  s_axi_araddr,
    // AXI4-Lite read data
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    // Shared divider bit port from config register zero
    input  wire logic        cfg0_prediv0_bit_we,
    input  wire logic        cfg0_prediv0_bit_wdata,
    output logic             cfg0_prediv0_bit,
    // Clock source ticks
    input  wire logic        external_highspeed_crystal,
    input  wire logic        internal_48mhz_rc_clock,
    input  wire logic        aux_pll_a_output,
    input  wire logic        aux_pll_b_x2,
    input  wire logic        system_clock,
    // Field outputs
    output logic             main_pll_ref_select,
    output logic             adc_prescaler_msb,
    output logic             audio_if2_clock_select,
    output logic             audio_if1_clock_select,
    output logic             prediv0_input_select,
    output logic [3:0]       aux_pll_b_multiplier,
    output logic [3:0]       aux_pll_a_multiplier,
    output logic [3:0]       pre_divider_one,
    output logic [3:0]       pre_divider_zero,
    // Decoded factors, zero for reserved codes
    output logic [4:0]       aux_pll_b_factor,
    output logic [4:0]       aux_pll_a_factor,
    // Selected and divided clock ticks
    output logic             main_pll_ref_tick,
    output logic             audio_if2_tick,
    output logic             audio_if1_tick,
    output logic             prediv0_tick,
    output logic             prediv1_tick
);

    // Register and bus state
    logic [31:0] cfg;              // Stored register
    logic [31:0] next_cfg;
    logic        aw_held;          // Write address captured
    logic        next_aw_held;
    logic [7:0]  aw_addr;          // Captured write address
    logic [7:0]  next_aw_addr;
    logic        w_held;           // Write data captured
    logic        next_w_held;
    logic [31:0] w_data;           // Captured write data
    logic [31:0] next_w_data;
    logic [3:0]  w_strb;           // Captured strobes
    logic [3:0]  next_w_strb;
    logic        next_bvalid;
    logic [1:0]  next_bresp;
    logic        next_rvalid;
    logic [31:0] next_rdata;
    logic [1:0]  next_rresp;
    logic        do_write;         // Both halves present, response free
    logic [31:0] wmask;            // Byte lane mask

    // Ready when the slot is empty and no response pending
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready  = !w_held && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;

    // Write channel capture and register update
    always_comb begin
        logic [7:0]  a;
        logic [31:0] d;
        logic [3:0]  s;
        a            = aw_held ? aw_addr : s_axi_awaddr;
        d            = w_held ? w_data : s_axi_wdata;
        s            = w_held ? w_strb : s_axi_wstrb;
        next_aw_held = aw_held;
        next_aw_addr = aw_addr;
        next_w_held  = w_held;
        next_w_data  = w_data;
        next_w_strb  = w_strb;
        next_bvalid  = s_axi_bvalid;
        next_bresp   = s_axi_bresp;
        next_cfg     = cfg;
        wmask        = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
        do_write     = (aw_held || (s_axi_awvalid && s_axi_awready)) &&
                       (w_held || (s_axi_wvalid && s_axi_wready));
        // Response taken
        if (s_axi_bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
        end
        if (do_write) begin
            next_aw_held = 1'b0;
            next_w_held  = 1'b0;
            next_bvalid  = 1'b1;
            if (a[7:2] == CCR_CFG1_OFFSET[7:2]) begin
                next_cfg   = (cfg & ~(wmask & CCR_CFG1_MASK)) |
                             (d & wmask & CCR_CFG1_MASK);
                next_bresp = CCR_RESP_OKAY;
            end else begin
                next_bresp = CCR_RESP_SLVERR;
            end
        end else begin
            // Hold whichever half arrived first
            if (s_axi_awvalid && s_axi_awready) begin
                next_aw_held = 1'b1;
                next_aw_addr = s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                next_w_held = 1'b1;
                next_w_data = s_axi_wdata;
                next_w_strb = s_axi_wstrb;
            end
        end
        if (cfg0_prediv0_bit_we) begin
            next_cfg[CCR_PREDIV0_LSB] = cfg0_prediv0_bit_wdata;
        end
    end

    // Read channel answer
    always_comb begin
        next_rvalid = s_axi_rvalid;
        next_rdata  = s_axi_rdata;
        next_rresp  = s_axi_rresp;
        if (s_axi_rvalid && s_axi_rready) begin
            next_rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            next_rvalid = 1'b1;
            if (s_axi_araddr[7:2] == CCR_CFG1_OFFSET[7:2]) begin
                next_rdata = cfg;
                next_rresp = CCR_RESP_OKAY;
            end else begin
                next_rdata = 32'h0000_0000;
                next_rresp = CCR_RESP_SLVERR;
            end
        end
    end

    // Register all bus and config state
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cfg          <= CCR_CFG1_RESET;
            aw_held      <= 1'b0;
            aw_addr      <= 8'h00;
            w_held       <= 1'b0;
            w_data       <= 32'h0000_0000;
            w_strb       <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= CCR_RESP_OKAY;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= CCR_RESP_OKAY;
        end else begin
            cfg          <= next_cfg;
            aw_held      <= next_aw_held;
            aw_addr      <= next_aw_addr;
            w_held       <= next_w_held;
            w_data       <= next_w_data;
            w_strb       <= next_w_strb;
            s_axi_bvalid <= next_bvalid;
            s_axi_bresp  <= next_bresp;
            s_axi_rvalid <= next_rvalid;
            s_axi_rdata  <= next_rdata;
            s_axi_rresp  <= next_rresp;
        end
    end

    // Field breakout
    always_comb begin
        main_pll_ref_select    = cfg[CCR_MAIN_PLL_REF_BIT];
        adc_prescaler_msb      = cfg[CCR_ADC_PSC_MSB_BIT];
        audio_if2_clock_select = cfg[CCR_AUDIO2_SEL_BIT];
        audio_if1_clock_select = cfg[CCR_AUDIO1_SEL_BIT];
        prediv0_input_select   = cfg[CCR_PREDIV0_SEL_BIT];
        aux_pll_b_multiplier   = cfg[CCR_PLLB_MUL_LSB +: 4];
        aux_pll_a_multiplier   = cfg[CCR_PLLA_MUL_LSB +: 4];
        pre_divider_one        = cfg[CCR_PREDIV1_LSB +: 4];
        pre_divider_zero       = cfg[CCR_PREDIV0_LSB +: 4];
        cfg0_prediv0_bit       = cfg[CCR_PREDIV0_LSB];
        aux_pll_b_factor       = ccr_mul_decode(aux_pll_b_multiplier);
        aux_pll_a_factor       = ccr_mul_decode(aux_pll_a_multiplier);
    end

    logic ref_tick;                // Crystal or RC tick
    logic pd0_in;                  // Divider zero input

    ccr_src_mux u_ref_mux (
        .aclk    (aclk),
        .aresetn (aresetn),
        .src0    (external_highspeed_crystal),
        .src1    (internal_48mhz_rc_clock),
        .sel     (main_pll_ref_select),
        .out     (ref_tick)
    );
    assign main_pll_ref_tick = ref_tick;

    ccr_src_mux u_aud2_mux (
        .aclk    (aclk),
        .aresetn (aresetn),
        .src0    (system_clock),
        .src1    (aux_pll_b_x2),
        .sel     (audio_if2_clock_select),
        .out     (audio_if2_tick)
    );

    ccr_src_mux u_aud1_mux (
        .aclk    (aclk),
        .aresetn (aresetn),
        .src0    (system_clock),
        .src1    (aux_pll_b_x2),
        .sel     (audio_if1_clock_select),
        .out     (audio_if1_tick)
    );

    ccr_src_mux u_pd0_mux (
        .aclk    (aclk),
        .aresetn (aresetn),
        .src0    (ref_tick),
        .src1    (aux_pll_a_output),
        .sel     (prediv0_input_select),
        .out     (pd0_in)
    );

    ccr_prediv u_pd0 (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .src_tick (pd0_in),
        .div_code (pre_divider_zero),
        .div_tick (prediv0_tick)
    );

    ccr_prediv u_pd1 (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .src_tick (ref_tick),
        .div_code (pre_divider_one),
        .div_tick (prediv1_tick)
    );

    a_reset_zero: assert property (@(posedge aclk)
        !aresetn |=> cfg == 32'h0000_0000)
        else $error("cfg not zero after reset");
    a_ref_sel: assert property (@(posedge aclk) disable iff (!aresetn)
        $past(aresetn) |-> main_pll_ref_tick == $past(main_pll_ref_select ?
        internal_48mhz_rc_clock : external_highspeed_crystal))
        else $error("ref select wrong");
    a_shared_bit: assert property (@(posedge aclk) disable iff (!aresetn)
        cfg0_prediv0_bit_we |=> cfg[0] == $past(cfg0_prediv0_bit_wdata))
        else $error("shared bit lost");
    a_rsvd_code: assert property (@(posedge aclk) disable iff (!aresetn)
        (aux_pll_b_multiplier == 4'hD) |-> aux_pll_b_factor == 5'h00)
        else $error("reserved code decoded");
    a_mul_b20: assert property (@(posedge aclk) disable iff (!aresetn)
        (aux_pll_b_multiplier == 4'hF) |-> aux_pll_b_factor == 5'h14)
        else $error("x20 wrong");
    a_mul_a8: assert property (@(posedge aclk) disable iff (!aresetn)
        (aux_pll_a_multiplier == 4'h6) |-> aux_pll_a_factor == 5'h08)
        else $error("x8 wrong");
    a_pd0_pass: assert property (@(posedge aclk) disable iff (!aresetn)
        (pd0_in && pre_divider_zero == 4'h0 && $stable(pre_divider_zero))
        |=> prediv0_tick)
        else $error("divider zero dropped tick");
    a_rsvd_zero: assert property (@(posedge aclk) disable iff (!aresetn)
        (cfg & ~32'h6007_FFFF) == 32'h0000_0000)
        else $error("reserved bit set");
    c_write: cover property (@(posedge aclk) do_write);
    c_read: cover property (@(posedge aclk) s_axi_rvalid && s_axi_rready);
    c_shared: cover property (@(posedge aclk) cfg0_prediv0_bit_we);

endmodule : ccr_cfg1
`default_nettype wire

// [verification/ccr_cfg1_tb.sv]
// Self-checking bench for clock configuration register one
`timescale 1ns/1ps
`default_nettype none
module ccr_cfg1_tb;
    import ccr_pkg::*;

    // Clock, reset and bus master signals
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
    logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
    logic        s_axi_rready = 1'b0;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0000_0000;
    logic [3:0]  s_axi_wstrb = 4'h0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic        s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    // Shared bit port and source ticks
    logic        cfg0_prediv0_bit_we = 1'b0;
    logic        cfg0_prediv0_bit_wdata = 1'b0;
    logic        cfg0_prediv0_bit;
    logic [4:0]  src = 5'h00;
    // Field and tick outputs
    logic main_pll_ref_select, adc_prescaler_msb, audio_if2_clock_select;
    logic audio_if1_clock_select, prediv0_input_select;
    logic [3:0] aux_pll_b_multiplier, aux_pll_a_multiplier;
    logic [3:0] pre_divider_one, pre_divider_zero;
    logic [4:0] aux_pll_b_factor, aux_pll_a_factor;
    logic main_pll_ref_tick, audio_if2_tick, audio_if1_tick;
    logic prediv0_tick, prediv1_tick;
    // Model register and counters
    logic [31:0] reg_m = 32'h0000_0000;
    int          n_fail = 0;
    int          total_checks = 0;
    int          cyc = 0;
    localparam logic [7:0] CFG   = 8'h2C;
    localparam int         LIMIT = 20000;

    // Clock at 200 MHz
    always #2.5 aclk = ~aclk;

    ccr_cfg1 dut_u (
        .aclk, .aresetn,
        .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
        .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
        .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
        .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp,
        .cfg0_prediv0_bit_we, .cfg0_prediv0_bit_wdata, .cfg0_prediv0_bit,
        .external_highspeed_crystal(src[0]),
        .internal_48mhz_rc_clock(src[1]),
        .aux_pll_a_output(src[2]),
        .aux_pll_b_x2(src[3]),
        .system_clock(src[4]),
        .main_pll_ref_select, .adc_prescaler_msb, .audio_if2_clock_select,
        .audio_if1_clock_select, .prediv0_input_select,
        .aux_pll_b_multiplier, .aux_pll_a_multiplier,
        .pre_divider_one, .pre_divider_zero,
        .aux_pll_b_factor, .aux_pll_a_factor,
        .main_pll_ref_tick, .audio_if2_tick, .audio_if1_tick,
        .prediv0_tick, .prediv1_tick
    );

    // Verdict and end of run
    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : summarize

    // Exact compare of a design value
    task automatic check(input logic [31:0] got, input logic [31:0] exp,
                         input string what);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : check

    // Tick count compare, one extra tick allowed for leftover divider phase
    task automatic check_cnt(input int got, input int exp, input string what);
        total_checks++;
        if ((exp == 0) ? (got != 0) : (got < exp || got > exp + 1)) begin
            n_fail++;
            $display("[ERR] %0t %s got %0d exp %0d", $time, what, got, exp);
        end
    endtask : check_cnt

    // Multiplier factor expected from a code, zero when reserved
    function automatic logic [4:0] mul_exp(input logic [3:0] c);
        if (c >= 4'h6 && c <= 4'hC) return {1'b0, c} + 5'h02;
        if (c == 4'hE) return 5'h10;
        if (c == 4'hF) return 5'h14;
        return 5'h00;
    endfunction : mul_exp

    // Field levels and factors against the model
    task automatic check_fields();
        check({main_pll_ref_select, adc_prescaler_msb, audio_if2_clock_select,
               audio_if1_clock_select, prediv0_input_select,
               aux_pll_b_multiplier, aux_pll_a_multiplier,
               pre_divider_one, pre_divider_zero},
              {reg_m[30:29], reg_m[18:0]}, "fields");
        check({aux_pll_b_factor, aux_pll_a_factor},
              {mul_exp(reg_m[15:12]), mul_exp(reg_m[11:8])}, "factors");
        check(cfg0_prediv0_bit, reg_m[0], "shared bit");
    endtask : check_fields

    // Write both halves together, wait for the response
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
                             input logic [3:0] s, input logic [1:0] er);
        bit aw_done;
        bit w_done;
        aw_done = 1'b0;
        w_done = 1'b0;
        @(posedge aclk);
        s_axi_awvalid <= 1'b1;
        s_axi_awaddr <= a;
        s_axi_wvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_bready <= 1'b1;
        while (!(aw_done && w_done)) begin
            @(posedge aclk);
            if (!aw_done && s_axi_awready === 1'b1) begin
                aw_done = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (!w_done && s_axi_wready === 1'b1) begin
                w_done = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        check(s_axi_bresp, er, "bresp");
        if (er == CCR_RESP_OKAY) begin
            for (int k = 0; k < 4; k++) begin
                if (s[k]) reg_m[8*k +: 8] = d[8*k +: 8];
            end
            reg_m = reg_m & CCR_CFG1_MASK;
        end
    endtask : axi_write

    // Read one word and compare data and response
    task automatic axi_read(input logic [7:0] a, input logic [31:0] ed,
                            input logic [1:0] er);
        @(posedge aclk);
        s_axi_arvalid <= 1'b1;
        s_axi_araddr <= a;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        check(s_axi_rdata, ed, "rdata");
        check(s_axi_rresp, er, "rresp");
    endtask : axi_read

    // Shared bit written from the config zero side
    task automatic share(input logic v);
        @(posedge aclk);
        cfg0_prediv0_bit_we <= 1'b1;
        cfg0_prediv0_bit_wdata <= v;
        @(posedge aclk);
        cfg0_prediv0_bit_we <= 1'b0;
        reg_m[0] = v;
        @(posedge aclk);
    endtask : share

    // Pulse the sources in mask m for n cycles and count output ticks
    task automatic run_ticks(input logic [4:0] m, input int n);
        int         got [5];
        logic [4:0] t;
        logic       ref_on;
        logic       in0;
        for (int j = 0; j < 5; j++) got[j] = 0;
        for (int k = 0; k < n + 6; k++) begin
            @(posedge aclk);
            t = {prediv1_tick, prediv0_tick, audio_if1_tick, audio_if2_tick,
                 main_pll_ref_tick};
            for (int j = 0; j < 5; j++) got[j] += int'(t[j] === 1'b1);
            src <= (k < n) ? m : 5'h00;
        end
        ref_on = reg_m[30] ? m[1] : m[0];
        in0 = reg_m[16] ? m[2] : ref_on;
        check_cnt(got[0], ref_on ? n : 0, "ref ticks");
        check_cnt(got[1], (reg_m[18] ? m[3] : m[4]) ? n : 0, "if2");
        check_cnt(got[2], (reg_m[17] ? m[3] : m[4]) ? n : 0, "if1");
        check_cnt(got[3], in0 ? n / (int'(reg_m[3:0]) + 1) : 0, "d0");
        check_cnt(got[4], ref_on ? n / (int'(reg_m[7:4]) + 1) : 0, "d1");
    endtask : run_ticks

    // Hang guard
    always @(posedge aclk) begin
        cyc++;
        if (cyc == LIMIT) begin
            n_fail++;
            $display("[ERR] %0t run timed out", $time);
            summarize();
        end
    end

    // Main sequence
    initial begin
        int p0;
        int p1;
        void'($urandom(34));
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        axi_read(CFG, 32'h0000_0000, CCR_RESP_OKAY);
        check_fields();
        $display("test reset done");
        // software keeps reserved bits zero, they read zero
        axi_write(CFG, 32'h6007_FFFF, 4'hF, CCR_RESP_OKAY);
        axi_read(CFG, 32'h6007_FFFF, CCR_RESP_OKAY);
        check_fields();
        axi_write(CFG, 32'h0000_0000, 4'h2, CCR_RESP_OKAY);
        axi_read(CFG, 32'h6007_00FF, CCR_RESP_OKAY);
        axi_write(8'h30, 32'h0000_0000, 4'hF, CCR_RESP_SLVERR);
        axi_read(8'h30, 32'h0000_0000, CCR_RESP_SLVERR);
        axi_read(CFG, 32'h6007_00FF, CCR_RESP_OKAY);
        $display("test access done");
        for (int i = 0; i < 16; i++) begin
            axi_write(CFG, {16'h0000, 4'(i), 4'(15 - i), 8'h00}, 4'hF,
                      CCR_RESP_OKAY);
            axi_read(CFG, reg_m, CCR_RESP_OKAY);
            check_fields();
        end
        $display("test multiplier done");
        share(1'b1);
        axi_read(CFG, reg_m, CCR_RESP_OKAY);
        axi_write(CFG, 32'h0000_0000, 4'hF, CCR_RESP_OKAY);
        check_fields();
        share(1'b1);
        share(1'b0);
        axi_read(CFG, reg_m, CCR_RESP_OKAY);
        $display("test shared bit done");
        for (int i = 0; i < 10; i++) begin
            axi_write(CFG, $urandom() & 32'h6007_00FF, 4'hF,
                      CCR_RESP_OKAY);
            axi_read(CFG, reg_m, CCR_RESP_OKAY);
            p0 = int'(reg_m[3:0]) + 1;
            p1 = int'(reg_m[7:4]) + 1;
            run_ticks(5'($urandom_range(31, 1)),
                      40 * ((p0 > p1) ? p0 : p1));
        end
        $display("test ticks done");
        summarize();
    end

endmodule : ccr_cfg1_tb
`default_nettype wire
